// ==== hw/cmp_pkg.sv ====
package cmp_pkg;

  // Execution state: only three legal combinations exist
  typedef enum logic [1:0] {
    CMP_PRIV_THREAD,
    CMP_USER_THREAD,
    CMP_PRIV_HANDLER
  } cmp_mode_t;

  // Register file geometry
  localparam int CMP_XLEN = 32;
  localparam int CMP_NUM_ARCH_REGS = 16;
  localparam int CMP_PHYS_REGS = 17;
  localparam int CMP_PHYS_AW = 5;

  // Architectural register numbers
  localparam logic [3:0] CMP_REG_LOW_LAST = 4'h7;
  localparam logic [3:0] CMP_REG_SP = 4'hD;
  localparam logic [3:0] CMP_REG_PC = 4'hF;

  // Physical slots of the two stack pointers
  localparam logic [4:0] CMP_SLOT_MAIN_SP = 5'h0D;
  localparam logic [4:0] CMP_SLOT_PROC_SP = 5'h10;

  // Alignment masks for stack pointer and program counter writes
  localparam logic [31:0] CMP_SP_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] CMP_PC_MASK = 32'hFFFFFFFE;

  // Mode control field positions and reset value
  localparam int CMP_CTRL_USER_BIT = 0;
  localparam int CMP_CTRL_SPSEL_BIT = 1;
  localparam logic [1:0] CMP_CTRL_RST = 2'h0;

  // Exception bookkeeping
  localparam int CMP_EXC_NUM_W = 9;
  localparam logic [8:0] CMP_EXC_NONE = 9'h000;
  localparam logic [7:0] CMP_DEPTH_RST = 8'h00;
  localparam logic [7:0] CMP_DEPTH_MAX = 8'hFF;

  // Protected access classes, one bit each
  localparam int CMP_ACC_CLASSES = 4;
  localparam int CMP_ACC_INSTR = 0;
  localparam int CMP_ACC_SPECIAL = 1;
  localparam int CMP_ACC_CONFIG = 2;
  localparam int CMP_ACC_DEBUG = 3;

  // First-halfword prefixes that open a 32-bit encoding
  localparam logic [4:0] CMP_WIDE_PFX_A = 5'h1D;
  localparam logic [4:0] CMP_WIDE_PFX_B = 5'h1E;
  localparam logic [4:0] CMP_WIDE_PFX_C = 5'h1F;

  // Data access sizes and byte lane masks
  localparam logic [1:0] CMP_SIZE_BYTE = 2'h0;
  localparam logic [1:0] CMP_SIZE_HALF = 2'h1;
  localparam logic [7:0] CMP_LANES_BYTE = 8'h01;
  localparam logic [7:0] CMP_LANES_HALF = 8'h03;
  localparam logic [7:0] CMP_LANES_WORD = 8'h0F;

  // Bit-band alias field positions
  localparam int CMP_BB_BIT_LSB = 2;
  localparam int CMP_BB_BYTE_LSB = 5;

endpackage

// ==== hw/cmp_regfile.sv ====
`timescale 1ns/10ps
// Register storage with one write and one registered read port
module cmp_regfile #(
  parameter int DEPTH = 17,
  parameter int WIDTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // Storage write, no reset on the array
  always_ff @(posedge sys_clk_i)
  begin
    if (we_i)
    begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= '0;
    end
    else if (re_i)
    begin
      rdata_o <= mem_ff[raddr_i];
    end
  end

endmodule

// ==== hw/cmp_mem_align.sv ====
`timescale 1ns/10ps
// Data access shaping: bit-band alias translation and lane split
module cmp_mem_align #(
  parameter logic [31:0] BB_ALIAS_BASE = 32'h22000000,
  parameter logic [31:0] BB_REGION_BASE = 32'h20000000,
  parameter int ALIAS_BITS = 25
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic valid_i,
  input wire logic [31:0] addr_i,
  input wire logic [1:0] size_i,
  output logic valid_o,
  output logic [31:0] addr_o,
  output logic bitband_o,
  output logic [2:0] bit_o,
  output logic [3:0] lanes_first_o,
  output logic [3:0] lanes_second_o,
  output logic split_o
);

  logic hit;
  logic [ALIAS_BITS-6:0] byte_off;
  logic [31:0] nxt_addr;
  logic [7:0] lanes;
  logic [7:0] shifted;

  // Alias decode and byte address of the aliased bit
  assign hit = (addr_i[31:ALIAS_BITS] == BB_ALIAS_BASE[31:ALIAS_BITS]);
  assign byte_off = addr_i[ALIAS_BITS-1:cmp_pkg::CMP_BB_BYTE_LSB];
  assign nxt_addr = hit ? (BB_REGION_BASE + {{(37-ALIAS_BITS){1'b0}}, byte_off}) : addr_i;

  // Lane mask by size, shifted by the misalignment
  always_comb
  begin
    lanes = cmp_pkg::CMP_LANES_WORD;
    if (hit || size_i == cmp_pkg::CMP_SIZE_BYTE)
    begin
      lanes = cmp_pkg::CMP_LANES_BYTE;
    end
    else if (size_i == cmp_pkg::CMP_SIZE_HALF)
    begin
      lanes = cmp_pkg::CMP_LANES_HALF;
    end
  end
  assign shifted = lanes << nxt_addr[1:0];

  // Registered access description
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      valid_o <= 1'b0;
      addr_o <= '0;
      bitband_o <= 1'b0;
      bit_o <= '0;
      lanes_first_o <= '0;
      lanes_second_o <= '0;
      split_o <= 1'b0;
    end
    else
    begin
      valid_o <= valid_i;
      if (valid_i)
      begin
        addr_o <= nxt_addr;
        bitband_o <= hit;
        bit_o <= hit ? addr_i[cmp_pkg::CMP_BB_BIT_LSB+2:cmp_pkg::CMP_BB_BIT_LSB] : 3'h0;
        lanes_first_o <= shifted[3:0];
        lanes_second_o <= shifted[7:4];
        split_o <= |shifted[7:4];
      end
    end
  end

endmodule

// ==== hw/cmp_core_ctrl.sv ====
// What this block does
// - Handler mode only ever runs at the privileged level, never at user level.
// - The execution state is one of privileged handler, privileged thread or user thread.
// - At user level, protected instructions, special and configuration registers and debug parts fault.
// - At the privileged level every instruction and register access goes through without a privilege fault.
// - Exception service runs in handler mode, otherwise the core is in thread mode.
// - All sixteen core registers are 32 bits wide.
// - Registers zero to seven are reachable by every encoding naming a general register.
// - Registers eight to twelve are reachable by all 32-bit encodings but not all 16-bit ones.
// - The decoder takes a mixed stream of 16-bit and 32-bit compact encodings.
// - The legacy fixed-width instruction set is not executed; switching to it faults.
// - Two stack pointers exist, a main one and a process one.
// - Bit-band aliasing gives atomic single-bit reads and writes.
// - Unaligned data accesses are supported for contiguous storage.
// - The external reset pin is active low and reads deasserted when nobody drives it.
// - The process stack pointer is used only in user-level thread execution, main otherwise.
// - Mode control bit 0 picks thread privilege, bit 1 the stack in user thread, and bit 1 stays 0 in handler.
`timescale 1ns/10ps
module cmp_core_ctrl (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic external_reset_n_i,
  input wire logic external_reset_drv_i,
  input wire logic exc_entry_i,
  input wire logic [8:0] exc_num_i,
  input wire logic exc_return_i,
  input wire logic acc_valid_i,
  input wire logic [3:0] acc_class_i,
  input wire logic ctrl_wr_i,
  input wire logic [1:0] ctrl_wdata_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_hw_i,
  input wire logic bx_valid_i,
  input wire logic [31:0] bx_target_i,
  input wire logic rd_valid_i,
  input wire logic [3:0] rd_reg_i,
  input wire logic rd_wide_i,
  input wire logic rd_hi_ok_i,
  input wire logic wr_valid_i,
  input wire logic [3:0] wr_reg_i,
  input wire logic wr_wide_i,
  input wire logic wr_hi_ok_i,
  input wire logic [31:0] wr_data_i,
  input wire logic mem_valid_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [1:0] mem_size_i,
  output logic handler_o,
  output logic user_o,
  output logic psp_sel_o,
  output logic [1:0] ctrl_o,
  output logic [8:0] exc_num_o,
  output logic priv_fault_o,
  output logic isa_fault_o,
  output logic reg_fault_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic instr_valid_o,
  output logic instr_wide_o,
  output logic instr_second_o,
  output logic mem_valid_o,
  output logic [31:0] mem_addr_o,
  output logic mem_bitband_o,
  output logic [2:0] mem_bit_o,
  output logic [3:0] mem_lanes_first_o,
  output logic [3:0] mem_lanes_second_o,
  output logic mem_split_o
);

  logic rst;
  logic pin_level;
  cmp_pkg::cmp_mode_t mode_ff;
  cmp_pkg::cmp_mode_t nxt_mode;
  logic [1:0] ctrl_ff;
  logic [1:0] nxt_ctrl;
  logic saved_spsel_ff;
  logic [7:0] depth_ff;
  logic [7:0] nxt_depth;
  logic [8:0] nxt_exc_num;
  logic is_user;
  logic last_return;
  logic nxt_priv_fault;
  logic second_ff;
  logic wide_pfx;
  logic rd_ok;
  logic wr_ok;
  logic rd_en;
  logic wr_en;
  logic [4:0] rd_slot;
  logic [4:0] wr_slot;
  logic [31:0] wr_value;

  // Undriven pin reads high, low level on the pin resets the core
  assign pin_level = external_reset_drv_i ? external_reset_n_i : 1'b1;
  assign rst = reset_i | ~pin_level;

  assign is_user = (mode_ff == cmp_pkg::CMP_USER_THREAD);
  assign last_return = exc_return_i && (depth_ff == 8'h01);

  // Nesting depth of active exceptions
  always_comb
  begin
    nxt_depth = depth_ff;
    if (exc_entry_i)
    begin
      if (depth_ff != cmp_pkg::CMP_DEPTH_MAX)
      begin
        nxt_depth = depth_ff + 8'h01;
      end
    end
    else if (exc_return_i && depth_ff != cmp_pkg::CMP_DEPTH_RST)
    begin
      nxt_depth = depth_ff - 8'h01;
    end
  end

  // Mode control value, bit 1 held at 0 while in handler
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (exc_entry_i)
    begin
      nxt_ctrl[cmp_pkg::CMP_CTRL_SPSEL_BIT] = 1'b0;
    end
    else if (last_return)
    begin
      nxt_ctrl[cmp_pkg::CMP_CTRL_SPSEL_BIT] = saved_spsel_ff;
    end
    else if (ctrl_wr_i && !is_user)
    begin
      nxt_ctrl[cmp_pkg::CMP_CTRL_USER_BIT] = ctrl_wdata_i[cmp_pkg::CMP_CTRL_USER_BIT];
      if (mode_ff != cmp_pkg::CMP_PRIV_HANDLER)
      begin
        nxt_ctrl[cmp_pkg::CMP_CTRL_SPSEL_BIT] = ctrl_wdata_i[cmp_pkg::CMP_CTRL_SPSEL_BIT];
      end
    end
  end

  // Execution state transitions
  always_comb
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      cmp_pkg::CMP_PRIV_THREAD:
      begin
        if (exc_entry_i)
        begin
          nxt_mode = cmp_pkg::CMP_PRIV_HANDLER;
        end
        else if (ctrl_wr_i && ctrl_wdata_i[cmp_pkg::CMP_CTRL_USER_BIT])
        begin
          nxt_mode = cmp_pkg::CMP_USER_THREAD;
        end
      end
      cmp_pkg::CMP_USER_THREAD:
      begin
        if (exc_entry_i)
        begin
          nxt_mode = cmp_pkg::CMP_PRIV_HANDLER;
        end
      end
      cmp_pkg::CMP_PRIV_HANDLER:
      begin
        if (last_return && !exc_entry_i)
        begin
          nxt_mode = nxt_ctrl[cmp_pkg::CMP_CTRL_USER_BIT] ? cmp_pkg::CMP_USER_THREAD
                                                            : cmp_pkg::CMP_PRIV_THREAD;
        end
      end
      default:
      begin
        nxt_mode = cmp_pkg::CMP_PRIV_THREAD;
      end
    endcase
  end

  // Active exception number
  always_comb
  begin
    nxt_exc_num = exc_num_o;
    if (exc_entry_i)
    begin
      nxt_exc_num = exc_num_i;
    end
    else if (last_return)
    begin
      nxt_exc_num = cmp_pkg::CMP_EXC_NONE;
    end
  end

  // Execution state and mode control registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst)
    begin
      mode_ff <= cmp_pkg::CMP_PRIV_THREAD;
      ctrl_ff <= cmp_pkg::CMP_CTRL_RST;
      depth_ff <= cmp_pkg::CMP_DEPTH_RST;
      saved_spsel_ff <= 1'b0;
      exc_num_o <= cmp_pkg::CMP_EXC_NONE;
    end
    else
    begin
      mode_ff <= nxt_mode;
      ctrl_ff <= nxt_ctrl;
      depth_ff <= nxt_depth;
      exc_num_o <= nxt_exc_num;
      if (exc_entry_i && depth_ff == cmp_pkg::CMP_DEPTH_RST)
      begin
        saved_spsel_ff <= ctrl_ff[cmp_pkg::CMP_CTRL_SPSEL_BIT];
      end
    end
  end

  // Registered view of the execution state
  always_ff @(posedge sys_clk_i)
  begin
    if (rst)
    begin
      handler_o <= 1'b0;
      user_o <= 1'b0;
      psp_sel_o <= 1'b0;
      ctrl_o <= cmp_pkg::CMP_CTRL_RST;
    end
    else
    begin
      handler_o <= (nxt_mode == cmp_pkg::CMP_PRIV_HANDLER);
      user_o <= (nxt_mode == cmp_pkg::CMP_USER_THREAD);
      psp_sel_o <= (nxt_mode == cmp_pkg::CMP_USER_THREAD) && nxt_ctrl[cmp_pkg::CMP_CTRL_SPSEL_BIT];
      ctrl_o <= nxt_ctrl;
    end
  end

  // Privilege check on protected accesses and mode control writes
  assign nxt_priv_fault = is_user && ((acc_valid_i && (|acc_class_i)) || ctrl_wr_i);

  // Fault pulses
  always_ff @(posedge sys_clk_i)
  begin
    if (rst)
    begin
      priv_fault_o <= 1'b0;
      isa_fault_o <= 1'b0;
      reg_fault_o <= 1'b0;
    end
    else
    begin
      priv_fault_o <= nxt_priv_fault;
      isa_fault_o <= bx_valid_i && !bx_target_i[0];
      reg_fault_o <= (rd_valid_i && !rd_ok) || (wr_valid_i && !wr_ok);
    end
  end

  // Encoding length of each incoming halfword
  assign wide_pfx = (instr_hw_i[15:11] == cmp_pkg::CMP_WIDE_PFX_A) ||
                    (instr_hw_i[15:11] == cmp_pkg::CMP_WIDE_PFX_B) ||
                    (instr_hw_i[15:11] == cmp_pkg::CMP_WIDE_PFX_C);

  // Halfword stream tracking for mixed-width encodings
  always_ff @(posedge sys_clk_i)
  begin
    if (rst)
    begin
      second_ff <= 1'b0;
      instr_valid_o <= 1'b0;
      instr_wide_o <= 1'b0;
      instr_second_o <= 1'b0;
    end
    else
    begin
      instr_valid_o <= instr_valid_i;
      if (instr_valid_i)
      begin
        second_ff <= !second_ff && wide_pfx;
        instr_second_o <= second_ff;
        instr_wide_o <= second_ff || wide_pfx;
      end
    end
  end

  // Register reach by encoding width
  assign rd_ok = rd_wide_i || (rd_reg_i <= cmp_pkg::CMP_REG_LOW_LAST) || rd_hi_ok_i;
  assign wr_ok = wr_wide_i || (wr_reg_i <= cmp_pkg::CMP_REG_LOW_LAST) || wr_hi_ok_i;
  assign rd_en = rd_valid_i && rd_ok;
  assign wr_en = wr_valid_i && wr_ok;

  // Banked stack pointer slot selection
  assign rd_slot = (rd_reg_i == cmp_pkg::CMP_REG_SP && psp_sel_o) ? cmp_pkg::CMP_SLOT_PROC_SP
                                                                  : {1'b0, rd_reg_i};
  assign wr_slot = (wr_reg_i == cmp_pkg::CMP_REG_SP && psp_sel_o) ? cmp_pkg::CMP_SLOT_PROC_SP
                                                                  : {1'b0, wr_reg_i};

  // Stack pointer word aligned, program counter halfword aligned
  always_comb
  begin
    wr_value = wr_data_i;
    if (wr_reg_i == cmp_pkg::CMP_REG_SP)
    begin
      wr_value = wr_data_i & cmp_pkg::CMP_SP_MASK;
    end
    else if (wr_reg_i == cmp_pkg::CMP_REG_PC)
    begin
      wr_value = wr_data_i & cmp_pkg::CMP_PC_MASK;
    end
  end

  // Read answer strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (rst)
    begin
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_en;
    end
  end

  // Core register storage including both stack pointers
  cmp_regfile #(
    .DEPTH(cmp_pkg::CMP_PHYS_REGS),
    .WIDTH(cmp_pkg::CMP_XLEN),
    .AW(cmp_pkg::CMP_PHYS_AW)
  ) u_regs (
    .sys_clk_i(sys_clk_i),
    .reset_i(rst),
    .we_i(wr_en),
    .waddr_i(wr_slot),
    .wdata_i(wr_value),
    .re_i(rd_en),
    .raddr_i(rd_slot),
    .rdata_o(rd_data_o)
  );

  // Data access shaping
  cmp_mem_align u_align (
    .sys_clk_i(sys_clk_i),
    .reset_i(rst),
    .valid_i(mem_valid_i),
    .addr_i(mem_addr_i),
    .size_i(mem_size_i),
    .valid_o(mem_valid_o),
    .addr_o(mem_addr_o),
    .bitband_o(mem_bitband_o),
    .bit_o(mem_bit_o),
    .lanes_first_o(mem_lanes_first_o),
    .lanes_second_o(mem_lanes_second_o),
    .split_o(mem_split_o)
  );

endmodule

// ==== tb/cmp_core_ctrl_props.sv ====
`timescale 1ns/10ps
// Property checker for the mode and privilege controller
module cmp_core_ctrl_props (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic external_reset_n_i,
  input wire logic external_reset_drv_i,
  input wire logic exc_entry_i,
  input wire logic acc_valid_i,
  input wire logic [3:0] acc_class_i,
  input wire logic ctrl_wr_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_hw_i,
  input wire logic bx_valid_i,
  input wire logic [31:0] bx_target_i,
  input wire logic rd_valid_i,
  input wire logic [3:0] rd_reg_i,
  input wire logic rd_wide_i,
  input wire logic rd_hi_ok_i,
  input wire logic handler_o,
  input wire logic user_o,
  input wire logic psp_sel_o,
  input wire logic [1:0] ctrl_o,
  input wire logic priv_fault_o,
  input wire logic isa_fault_o,
  input wire logic reg_fault_o,
  input wire logic rd_valid_o,
  input wire logic instr_valid_o,
  input wire logic instr_wide_o,
  input wire logic instr_second_o
);
  // Internal reset also comes from a driven-low reset pin
  wire logic rst_any;
  assign rst_any = reset_i || (external_reset_drv_i && !external_reset_n_i);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_any);

  // Opening halfword of a wide encoding, echoed as first half
  sequence s_wide_first;
    instr_valid_i && instr_hw_i[15:11] >= 5'h1D ##1 instr_valid_o && instr_wide_o && !instr_second_o && instr_valid_i;
  endsequence

  AST_NO_USER_HANDLER: assert property (!(handler_o && user_o))
    else $error("user level seen in handler mode");
  AST_ENTRY: assert property (exc_entry_i |=> handler_o && !user_o && !psp_sel_o && !ctrl_o[1])
    else $error("exception entry did not give privileged handler");
  AST_PSP_USER: assert property (psp_sel_o |-> user_o && !handler_o && ctrl_o[1])
    else $error("process stack outside user thread");
  AST_PRIV_FAULT: assert property (acc_valid_i && (|acc_class_i) && user_o |=> priv_fault_o)
    else $error("protected access at user level without fault");
  AST_NO_PRIV_FAULT: assert property (!user_o |=> !priv_fault_o)
    else $error("privilege fault at privileged level");
  AST_CTRL_KEEP: assert property (ctrl_wr_i && user_o && !exc_entry_i |=> $stable(ctrl_o) && priv_fault_o)
    else $error("mode control changed from user level");
  AST_ISA: assert property (bx_valid_i |=> isa_fault_o == !$past(bx_target_i[0]))
    else $error("legacy set switch fault wrong");
  AST_REG_FAULT: assert property (rd_valid_i && !rd_wide_i && !rd_hi_ok_i && rd_reg_i > 4'h7 |=> reg_fault_o && !rd_valid_o)
    else $error("narrow access to high register not refused");
  AST_LOW_READ: assert property (rd_valid_i && rd_reg_i <= 4'h7 |=> rd_valid_o)
    else $error("low register read refused");
  AST_DECODE: assert property (s_wide_first |=> instr_valid_o && instr_wide_o && instr_second_o)
    else $error("second half of wide encoding not marked");
  AST_RESET_START: assert property ($fell(rst_any) |-> !handler_o && !user_o && !psp_sel_o && ctrl_o == 2'h0)
    else $error("state after reset not privileged thread");
endmodule

bind cmp_core_ctrl cmp_core_ctrl_props u_props (.*);

// ==== tb/cpu_mode_privilege_control_test.sv ====
`timescale 1ns/10ps
module cpu_mode_privilege_control_test;
  logic sys_clk_i, reset_i, external_reset_n_i, external_reset_drv_i, exc_entry_i, exc_return_i, acc_valid_i;
  logic ctrl_wr_i, instr_valid_i, bx_valid_i, rd_valid_i, rd_wide_i, rd_hi_ok_i, wr_valid_i, wr_wide_i, wr_hi_ok_i;
  logic mem_valid_i, handler_o, user_o, psp_sel_o, priv_fault_o, isa_fault_o, reg_fault_o, rd_valid_o;
  logic instr_valid_o, instr_wide_o, instr_second_o, mem_valid_o, mem_bitband_o, mem_split_o;
  logic [1:0] ctrl_wdata_i, mem_size_i, ctrl_o;
  logic [2:0] mem_bit_o;
  logic [3:0] acc_class_i, rd_reg_i, wr_reg_i, mem_lanes_first_o, mem_lanes_second_o;
  logic [8:0] exc_num_i, exc_num_o;
  logic [15:0] instr_hw_i;
  logic [31:0] bx_target_i, wr_data_i, mem_addr_i, rd_data_o, mem_addr_o;
  logic [31:0] rf [16];
  int error_cnt, checked, seed, h, c0, c1, sv, d, en, r, v, pf, pend, e;
  int hwq[$] = '{32'hE800, 32'h0000, 32'hF000, 32'hF800, 32'hF800, 32'h0000, 32'h4000};

  cmp_core_ctrl DUT (.*);

  // Clock source
  initial
  begin
    sys_clk_i = 0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic tick;
    @(negedge sys_clk_i);
  endtask

  // Drop all pulses and let one cycle pass
  task automatic gap;
    {exc_entry_i, exc_return_i, acc_valid_i, ctrl_wr_i, instr_valid_i, bx_valid_i} = '0;
    {rd_valid_i, wr_valid_i, mem_valid_i} = '0;
    tick;
  endtask

  task automatic chk_st;
    chk("handler", handler_o, h);
    chk("user", user_o, !h && c0);
    chk("psp_sel", psp_sel_o, !h && c0 && c1);
    chk("ctrl", ctrl_o, {c1[0], c0[0]});
    chk("exc_num", exc_num_o, en);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    error_cnt++;
    end_of_test;
  end

  initial
  begin
    seed = 29;
    {reset_i, external_reset_n_i} = 2'h3;
    {external_reset_drv_i, ctrl_wdata_i, mem_size_i, acc_class_i, rd_reg_i, wr_reg_i, exc_num_i} = '0;
    {rd_wide_i, rd_hi_ok_i, wr_wide_i, wr_hi_ok_i, instr_hw_i, bx_target_i, wr_data_i, mem_addr_i} = '0;
    gap;
    repeat (12) tick;
    reset_i = 0;
    {h, c0, c1, sv, d, en} = '0;
    tick;
    chk_st;
    // Random mode traffic with protected accesses
    repeat (60)
    begin
      v = $random(seed);
      pf = !h && c0;
      acc_valid_i = 1;
      acc_class_i = 4'h1 << v[15:14];
      ctrl_wdata_i = v[1:0];
      exc_num_i = 9'h010 | v[10:2];
      if (v[13:12] == 0)
      begin
        ctrl_wr_i = 1;
        if (!pf)
        begin
          c0 = v[0];
          c1 = h ? 0 : v[1];
        end
      end
      else if (v[13:12] == 1 && d == 0)
      begin
        exc_entry_i = 1;
        sv = c1;
        c1 = 0;
        h = 1;
        d = 1;
        en = exc_num_i;
      end
      else if (v[13:12] == 2)
      begin
        exc_return_i = 1;
        if (d == 1)
        begin
          h = 0;
          c1 = sv;
          d = 0;
          en = 0;
        end
      end
      tick;
      chk("priv_fault", priv_fault_o, pf);
      chk_st;
      gap;
    end
    $display("mode test done");
    // Undriven pin low must not reset, driven pin low must
    external_reset_n_i = 0;
    repeat (2) tick;
    chk_st;
    external_reset_drv_i = 1;
    repeat (2) tick;
    {external_reset_drv_i, external_reset_n_i} = 2'h1;
    {h, c0, c1, d, en} = '0;
    tick;
    chk_st;
    // Write every register through the wide form, read it narrow, then again wide if odd or narrow with rd_hi_ok_i if even
    for (r = 0; r < 16; r++)
    begin
      {wr_valid_i, wr_wide_i, wr_reg_i, wr_data_i} = {2'h3, r[3:0], 32'($random(seed))};
      rf[r] = wr_data_i & (r == 13 ? 32'hFFFFFFFC : r == 15 ? 32'hFFFFFFFE : 32'hFFFFFFFF);
      tick;
      chk("wr_fault", reg_fault_o, 0);
      gap;
      {rd_valid_i, rd_wide_i, rd_hi_ok_i, rd_reg_i} = {3'h4, r[3:0]};
      tick;
      chk("rd_valid", rd_valid_o, r < 8);
      chk("rd_fault", reg_fault_o, r > 7);
      if (r < 8)
        chk("rd_low", rd_data_o, rf[r]);
      gap;
      {rd_valid_i, rd_wide_i, rd_hi_ok_i} = {1'b1, r[0], !r[0]};
      tick;
      chk("rd_data", rd_data_o, rf[r]);
      gap;
    end
    {wr_valid_i, wr_wide_i, wr_hi_ok_i, wr_reg_i} = {3'h4, 4'h9};
    tick;
    chk("wr_fault", reg_fault_o, 1);
    gap;
    {rd_valid_i, rd_wide_i, rd_reg_i} = {2'h3, 4'h9};
    tick;
    chk("rd_kept", rd_data_o, rf[9]);
    gap;
    $display("register test done");
    // Mixed halfword stream
    pend = 0;
    foreach (hwq[i])
    begin
      {instr_valid_i, instr_hw_i} = {1'b1, hwq[i][15:0]};
      e = pend || hwq[i][15:11] >= 5'h1D;
      tick;
      chk("instr_valid", instr_valid_o, 1);
      chk("instr_wide", instr_wide_o, e);
      chk("instr_second", instr_second_o, pend);
      pend = !pend && e;
    end
    gap;
    for (r = 0; r < 2; r++)
    begin
      {bx_valid_i, bx_target_i} = {1'b1, 32'h00000100 | r};
      tick;
      chk("isa_fault", isa_fault_o, !r[0]);
      gap;
    end
    $display("decode test done");
    // Bit-band alias, then unaligned word spilling over
    {mem_valid_i, mem_addr_i, mem_size_i} = {1'b1, 32'h22000024, 2'h2};
    tick;
    chk("bb_addr", mem_addr_o, 32'h20000001);
    chk("bb_bit", {mem_bitband_o, mem_bit_o, mem_lanes_first_o}, 8'h92);
    gap;
    {mem_valid_i, mem_addr_i} = {1'b1, 32'h20000103};
    tick;
    chk("lanes", {mem_bitband_o, mem_split_o, mem_lanes_second_o, mem_lanes_first_o}, 10'h178);
    chk("mem_valid", mem_valid_o, 1);
    chk("ua_addr", mem_addr_o, 32'h20000103);
    gap;
    $display("memory test done");
    // Process stack pointer in user thread, main one in handler
    {ctrl_wr_i, ctrl_wdata_i} = 3'h7;
    c0 = 1;
    c1 = 1;
    tick;
    chk("priv_fault", priv_fault_o, 0);
    chk_st;
    gap;
    {wr_valid_i, wr_wide_i, wr_reg_i, wr_data_i} = {2'h3, 4'hD, 32'($random(seed))};
    sv = wr_data_i & 32'hFFFFFFFC;
    tick;
    gap;
    {rd_valid_i, rd_wide_i, rd_reg_i} = {2'h3, 4'hD};
    tick;
    chk("psp_read", rd_data_o, sv);
    gap;
    {exc_entry_i, exc_num_i} = {1'b1, 9'h0A5};
    h = 1;
    c1 = 0;
    en = 9'h0A5;
    tick;
    chk_st;
    gap;
    rd_valid_i = 1;
    tick;
    chk("msp_read", rd_data_o, rf[13]);
    gap;
    $display("stack test done");
    end_of_test;
  end
endmodule
